// ===== rtl/gate_pwm_pkg.sv
// Constants, types and helper functions shared by the gate drive block.
package gate_pwm_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;   // System clock period.
  localparam int IVL_STEP_NS   = 50;   // Turn-on/off interval step.
  localparam int IVL_STEP_CYC  =
    (IVL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DT_STEP_NS    = 50;   // Dead time per count.
  localparam int DT_STEP_CYC   = DT_STEP_NS / CLK_PERIOD_NS;
  localparam int DT_MIN_NS     = 100;  // Least dead time.
  localparam int DT_MIN_CYC    =
    (DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PW_CENTER_NS  = 20100; // Base period, center mode.
  localparam int PW_EDGE_NS    = 20050; // Base period, edge mode.
  localparam int PW_STEP_NS    = 800;   // Period added per count.
  localparam int PW_CENTER_CYC = PW_CENTER_NS / CLK_PERIOD_NS;
  localparam int PW_EDGE_CYC   = PW_EDGE_NS / CLK_PERIOD_NS;
  localparam int PW_STEP_CYC   = PW_STEP_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Widths and types
  // ==========================================================
  localparam int TMR_W = 9;            // Interval and dead timers.
  localparam int CNT_W = 16;           // PWM counter and duty.
  typedef logic [TMR_W-1:0] tmr_t;
  typedef logic [CNT_W-1:0] cnt_t;
  typedef logic [3:0]       cur_t;     // Programmed gate current.

  // Gate sequencer states.
  typedef enum logic [2:0] {
    G_OFF, G_ON1, G_ON2, G_ON, G_OFF1, G_OFF2
  } gate_state_e;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  SLEW_ADDR   = 8'h04;
  localparam logic [7:0]  DUTY_ADDR   = 8'h08; // Three words.
  localparam logic [7:0]  STATUS_ADDR = 8'h14;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] SLEW_RST    = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK   = 32'h003f_3f07;
  localparam logic [31:0] SLEW_MASK   = 32'h0fff_ffff;
  localparam int CTRL_SLEW_BIT = 0;    // Common slew mode enable.
  localparam int CTRL_ALIGN_BIT = 1;   // 0 center, 1 edge aligned.
  localparam int CTRL_EN_BIT   = 2;    // Bridge enable.
  localparam int CTRL_PW_LSB   = 8;    // Six-bit period count.
  localparam int CTRL_DT_LSB   = 16;   // Six-bit dead time count.
  localparam int SLEW_ON1_LSB  = 0;
  localparam int SLEW_ON2_LSB  = 4;
  localparam int SLEW_OFF1_LSB = 8;
  localparam int SLEW_OFF2_LSB = 12;
  localparam int SLEW_TON_LSB  = 16;
  localparam int SLEW_TOFF_LSB = 20;
  localparam int SLEW_VDS_LSB  = 24;
  localparam int ST_CUR_LSB    = 6;
  localparam int ST_PWM_LSB    = 12;
  localparam int ST_CNT_LSB    = 16;

  // Scales a field count by a step in cycles to timer width.
  function automatic tmr_t scaleCount(input logic [5:0] n,
                                      input int step);
    return TMR_W'(int'(n) * step);
  endfunction : scaleCount

endpackage : gate_pwm_pkg

// ===== rtl/gate_cfg_if.sv
// Interface carrying the drive configuration to the phase sequencers.
`timescale 1ns/1ps
interface gate_cfg_if;
  import gate_pwm_pkg::*;
  logic       enable;       // Bridge enabled.
  logic       slewEnable;   // One mode shared by every gate drive.
  cur_t       turnOnFirstCurrent;
  cur_t       turnOnSecondCurrent;
  cur_t       turnOffFirstCurrent;
  cur_t       turnOffSecondCurrent;
  logic [3:0] turnOnIntervalField;
  logic [3:0] turnOffFirstInterval;
  tmr_t       deadCycles;   // Dead time, already in cycles.
  modport src (output enable, slewEnable, turnOnFirstCurrent,
    turnOnSecondCurrent, turnOffFirstCurrent, turnOffSecondCurrent,
    turnOnIntervalField, turnOffFirstInterval, deadCycles);
  modport snk (input enable, slewEnable, turnOnFirstCurrent,
    turnOnSecondCurrent, turnOffFirstCurrent, turnOffSecondCurrent,
    turnOnIntervalField, turnOffFirstInterval, deadCycles);
endinterface : gate_cfg_if

// ===== rtl/phase_gate_seq.sv
// One phase: two gate sequencers with dead time between them.
`timescale 1ns/1ps
module phase_gate_seq (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Configuration and demand.
  gate_cfg_if.snk                cfg,
  input  wire logic              pwmHigh,
  // Comparators, high when Vds is below threshold.
  input  wire logic              vdsHighBelow,
  input  wire logic              vdsLowBelow,
  // Drive, index 0 low side, 1 high side.
  output logic [1:0]             gateOn,
  output logic [1:0]             currentDrive,
  output gate_pwm_pkg::cur_t [1:0] driveCurrent
);
  import gate_pwm_pkg::*;

  // Every check of this module runs on the one clock, off in reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Demand and commands
  // ==========================================================
  gate_state_e state_reg [2];  // Per gate sequencer state.
  tmr_t        tmr_reg [2];    // Per gate interval timer.
  tmr_t        dead_reg;       // Dead time down counter.
  logic [1:0]  want, isOn, isOff, onCmd, offCmd, fullOn, fullOff;
  logic        slewUp, slewDn;

  // In slew mode, a direction slews when any of its currents is set.
  assign slewUp = cfg.slewEnable &&
    (cfg.turnOnFirstCurrent != '0 || cfg.turnOnSecondCurrent != '0);
  assign slewDn = cfg.slewEnable &&
    (cfg.turnOffFirstCurrent != '0 || cfg.turnOffSecondCurrent != '0);
  assign want = {cfg.enable && pwmHigh, cfg.enable && !pwmHigh};
  // High side is on when Vbrg-Vsx is low, low side when Vsx is.
  assign fullOn  = {vdsHighBelow, vdsLowBelow};
  // Off is judged by the complementary comparator.
  assign fullOff = {vdsLowBelow, vdsHighBelow};

  for (genvar g = 0; g < 2; g++) begin : gate
    assign isOn[g]  = state_reg[g] inside {G_ON1, G_ON2, G_ON};
    assign isOff[g] = !isOn[g];
    assign offCmd[g] = !want[g] && isOn[g];
    // Turn-on waits out dead time and the partner's on state.
    assign onCmd[g] = want[g] && isOff[g] && dead_reg == '0 &&
                      !isOn[1-g];

    // Gate sequence; timers restart on each command.
    always_ff @(posedge clk) begin
      if (rst) begin
        state_reg[g] <= G_OFF;
        tmr_reg[g]   <= '0;
      end else if (offCmd[g]) begin
        tmr_reg[g]   <= scaleCount({2'b00, cfg.turnOffFirstInterval},
                                   IVL_STEP_CYC);
        state_reg[g] <= slewDn ? G_OFF1 : G_OFF;
      end else if (onCmd[g]) begin
        tmr_reg[g]   <= scaleCount({2'b00, cfg.turnOnIntervalField},
                                   IVL_STEP_CYC);
        state_reg[g] <= slewUp ? G_ON1 : G_ON;
      end else begin
        case (state_reg[g])
          G_ON1: begin
            tmr_reg[g] <= tmr_reg[g] - 1'b1;
            if (tmr_reg[g] <= 1) state_reg[g] <= G_ON2;
          end
          G_ON2:   if (fullOn[g]) state_reg[g] <= G_ON;
          G_OFF1: begin
            tmr_reg[g] <= tmr_reg[g] - 1'b1;
            if (tmr_reg[g] <= 1) state_reg[g] <= G_OFF2;
          end
          G_OFF2:  if (fullOff[g]) state_reg[g] <= G_OFF;
          default: state_reg[g] <= state_reg[g];
        endcase
      end
    end

    // Drive decode; a zero current means full switched drive.
    always_ff @(posedge clk) begin
      if (rst) begin
        gateOn[g] <= 1'b0;
        currentDrive[g] <= 1'b0;
        driveCurrent[g] <= '0;
      end else begin
        gateOn[g] <= isOn[g];
        case (state_reg[g])
          G_ON1:   driveCurrent[g] <= cfg.turnOnFirstCurrent;
          G_ON2:   driveCurrent[g] <= cfg.turnOnSecondCurrent;
          G_OFF1:  driveCurrent[g] <= cfg.turnOffFirstCurrent;
          G_OFF2:  driveCurrent[g] <= cfg.turnOffSecondCurrent;
          default: driveCurrent[g] <= '0;
        endcase
        currentDrive[g] <= (state_reg[g] == G_ON1 &&
            cfg.turnOnFirstCurrent != '0) ||
          (state_reg[g] == G_ON2 && cfg.turnOnSecondCurrent != '0) ||
          (state_reg[g] == G_OFF1 && cfg.turnOffFirstCurrent != '0) ||
          (state_reg[g] == G_OFF2 && cfg.turnOffSecondCurrent != '0);
      end
    end

    switchOn_a: assert property (onCmd[g] && !offCmd[g] && !slewUp
      |=> state_reg[g] == G_ON) else $error("switched on missed");
    switchOff_a: assert property (offCmd[g] && !slewDn
      |=> state_reg[g] == G_OFF) else $error("switched off missed");
    firstPhase_a: assert property (state_reg[g] == G_ON1 &&
      tmr_reg[g] <= 1 && want[g] |=> state_reg[g] == G_ON2)
      else $error("first current overran");
    voltHold_a: assert property (state_reg[g] == G_ON2 && fullOn[g] &&
      want[g] |=> state_reg[g] == G_ON ##1 currentDrive[g] == 1'b0)
      else $error("no voltage hold on");
    offHold_a: assert property (state_reg[g] == G_OFF2 && fullOff[g] &&
      !want[g] |=> state_reg[g] == G_OFF)
      else $error("no voltage hold off");
  end

  // Dead time restarts at every turn-off command of the phase.
  always_ff @(posedge clk) begin
    if (rst) dead_reg <= '0;
    else if (offCmd != 2'b00) dead_reg <= cfg.deadCycles;
    else if (dead_reg != '0) dead_reg <= dead_reg - 1'b1;
  end

  noOverlap_a: assert property (@(posedge clk) disable iff (rst)
    !(isOn[0] && isOn[1])) else $error("both gates on");
  slewRun_c: cover property (@(posedge clk) disable iff (rst)
    state_reg[1] == G_ON2 ##1 state_reg[1] == G_ON);
endmodule : phase_gate_seq

// ===== rtl/gate_slew_deadtime_pwm_control.sv
// Top of the gate slew, dead time and three-phase PWM control block.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module gate_slew_deadtime_pwm_control #(
  parameter int DUTY_W = 16              // Duty register width.
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Register port.
  input  wire logic [7:0]   regAddr,
  input  wire logic [31:0]  regWrData,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  output logic [31:0]       regRdData,
  // Drain-source comparators per phase.
  input  wire logic [2:0]   vdsHighBelow,
  input  wire logic [2:0]   vdsLowBelow,
  // Comparator threshold setting.
  output logic [3:0]        drainSourceThreshold,
  // Gate drive, index 2*phase + side, side 1 is high.
  output logic [5:0]        gateOn,
  output logic [5:0]        currentDrive,
  output logic [23:0]       driveCurrent,
  // PWM demand per phase.
  output logic [2:0]        pwmDemand
);
  import gate_pwm_pkg::*;

  // ==========================================================
  // Parameter check
  // ==========================================================
  // The duty word must hold the longest period of 7050 cycles.
  if (DUTY_W < 13 || DUTY_W > CNT_W) begin : badWidth
    $error("DUTY_W must lie between 13 and 16");
  end

  // ==========================================================
  // Register file
  // ==========================================================
  logic [31:0] ctrl_reg;             // Mode, period and dead time.
  logic [31:0] slew_reg;             // Currents, intervals, Vds.
  cnt_t        duty_reg [3];         // Duty in cycles per phase.
  cnt_t        cnt_reg;              // PWM period counter.
  cnt_t        period_reg;           // Period latched per cycle.
  logic        align_reg;            // Alignment latched per cycle.
  logic        wrap;                 // Last cycle of the period.
  logic [5:0]  deadTimeCount;        // Dead time field.
  logic [5:0]  pwmPeriodCount;       // Period field.
  logic        pwmAlignmentSelect;   // Alignment field.
  logic [1:0]  dutyIdx;              // Duty word selected.

  assign deadTimeCount = ctrl_reg[CTRL_DT_LSB +: 6];
  assign pwmPeriodCount = ctrl_reg[CTRL_PW_LSB +: 6];
  assign pwmAlignmentSelect = ctrl_reg[CTRL_ALIGN_BIT];
  assign dutyIdx = 2'((regAddr - DUTY_ADDR) >> 2);

  // True when an address falls on one of the duty words.
  function automatic logic isDuty(input logic [7:0] a);
    return a >= DUTY_ADDR && a < STATUS_ADDR && a[1:0] == 2'b00;
  endfunction : isDuty

  // Software writes; reserved bits are held at zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      slew_reg <= SLEW_RST;
    end else if (regWrite) begin
      if (regAddr == CTRL_ADDR) ctrl_reg <= regWrData & CTRL_MASK;
      if (regAddr == SLEW_ADDR) slew_reg <= regWrData & SLEW_MASK;
    end
  end

  // Duty words, cut to the configured width.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) duty_reg[i] <= '0;
    end else if (regWrite && isDuty(regAddr)) begin
      duty_reg[dutyIdx] <= CNT_W'(regWrData[DUTY_W-1:0]);
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRead) begin
      if (regAddr == CTRL_ADDR) begin
        regRdData <= ctrl_reg;
      end else if (regAddr == SLEW_ADDR) begin
        regRdData <= slew_reg;
      end else if (isDuty(regAddr)) begin
        regRdData <= 32'(duty_reg[dutyIdx]);
      end else if (regAddr == STATUS_ADDR) begin
        // Live gate, current mode, demand and counter state.
        regRdData <= {cnt_reg, 1'b0, pwmDemand,
                      currentDrive, gateOn};
      end else begin
        // Unmapped addresses read as zero.
        regRdData <= '0;
      end
    end else begin
      regRdData <= '0;
    end
  end

  // The comparator threshold goes straight to the analog side.
  assign drainSourceThreshold = slew_reg[SLEW_VDS_LSB +: 4];

  // ==========================================================
  // Dead time
  // ==========================================================
  tmr_t deadCycles;                  // Dead time in clock cycles.

  // Counts of 0, 1 and 2 all give the 100 ns floor.
  always_comb begin
    deadCycles = scaleCount(deadTimeCount, DT_STEP_CYC);
    if (deadCycles < TMR_W'(DT_MIN_CYC)) begin
      deadCycles = TMR_W'(DT_MIN_CYC);
    end
  end

  // ==========================================================
  // PWM period
  // ==========================================================
  // Cycles in one period for an alignment and a period count.
  function automatic cnt_t periodOf(input logic edgeMode,
                                    input logic [5:0] n);
    int base;
    base = edgeMode ? PW_EDGE_CYC : PW_CENTER_CYC;
    return CNT_W'(base + int'(n) * PW_STEP_CYC);
  endfunction : periodOf

  // Level of one phase for a duty at a counter position.
  function automatic logic pwmLevel(input cnt_t cnt,
                                    input cnt_t per,
                                    input cnt_t duty,
                                    input logic edgeMode);
    cnt_t lo;
    lo = '0;
    if (edgeMode) begin
      // Phases with a nonzero duty go high together at the counter start.
      return cnt < duty;
    end
    if (duty >= per) begin
      return 1'b1;
    end
    // Pulses sit centered on the middle of the period.
    lo = (per >> 1) - (duty >> 1);
    return cnt >= lo && cnt < lo + duty;
  endfunction : pwmLevel

  assign wrap = cnt_reg >= period_reg - 1'b1;

  // The period counter; the base period follows the field.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (wrap) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Period and alignment change only at a period boundary.
  always_ff @(posedge clk) begin
    if (rst) begin
      period_reg <= periodOf(CTRL_RST[CTRL_ALIGN_BIT],
                             CTRL_RST[CTRL_PW_LSB +: 6]);
      align_reg  <= CTRL_RST[CTRL_ALIGN_BIT];
    end else if (wrap) begin
      period_reg <= periodOf(pwmAlignmentSelect, pwmPeriodCount);
      align_reg  <= pwmAlignmentSelect;
    end
  end

  // Phase demand from the counter and each duty.
  always_ff @(posedge clk) begin
    if (rst) begin
      pwmDemand <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        pwmDemand[p] <= pwmLevel(cnt_reg, period_reg,
                                 duty_reg[p], align_reg);
      end
    end
  end

  // ==========================================================
  // Gate sequencers
  // ==========================================================
  gate_cfg_if cfgBus ();

  // One mode bit feeds every gate of every phase.
  assign cfgBus.enable = ctrl_reg[CTRL_EN_BIT];
  assign cfgBus.slewEnable = ctrl_reg[CTRL_SLEW_BIT];
  assign cfgBus.turnOnFirstCurrent = slew_reg[SLEW_ON1_LSB +: 4];
  assign cfgBus.turnOnSecondCurrent = slew_reg[SLEW_ON2_LSB +: 4];
  assign cfgBus.turnOffFirstCurrent = slew_reg[SLEW_OFF1_LSB +: 4];
  assign cfgBus.turnOffSecondCurrent = slew_reg[SLEW_OFF2_LSB +: 4];
  assign cfgBus.turnOnIntervalField = slew_reg[SLEW_TON_LSB +: 4];
  assign cfgBus.turnOffFirstInterval = slew_reg[SLEW_TOFF_LSB +: 4];
  assign cfgBus.deadCycles = deadCycles;

  for (genvar p = 0; p < 3; p++) begin : phase
    cur_t [1:0] cur;                 // Currents of both gates.

    phase_gate_seq seq (
      .clk          (clk),
      .rst          (rst),
      .cfg          (cfgBus),
      .pwmHigh      (pwmDemand[p]),
      .vdsHighBelow (vdsHighBelow[p]),
      .vdsLowBelow  (vdsLowBelow[p]),
      .gateOn       (gateOn[2*p +: 2]),
      .currentDrive (currentDrive[2*p +: 2]),
      .driveCurrent (cur)
    );
    assign driveCurrent[8*p +: 8] = cur;
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  deadFloor_a: assert property (deadCycles >= TMR_W'(DT_MIN_CYC))
    else $error("dead time below floor");
  deadScale_a: assert property (deadTimeCount > 6'h02 |->
    int'(deadCycles) == int'(deadTimeCount) * DT_STEP_CYC)
    else $error("dead time not scaled");
  periodLen_a: assert property (wrap ##1 !wrap |->
    period_reg == periodOf($past(pwmAlignmentSelect),
                           $past(pwmPeriodCount)))
    else $error("period mismatch");
  edgeRise_a: assert property (align_reg && cnt_reg == '0 &&
    duty_reg[0] != '0 |=> pwmDemand[0])
    else $error("edge pulse not at start");
  centerSym_a: assert property (!align_reg && cnt_reg ==
    (period_reg >> 1) && duty_reg[1] > 16'h0001 |=> pwmDemand[1])
    else $error("center pulse off center");

  edgeMode_c: cover property (align_reg && wrap);
  centerMode_c: cover property (!align_reg && wrap);
  slewOn_c: cover property (currentDrive[1] ##[1:200] !currentDrive[1]);
endmodule : gate_slew_deadtime_pwm_control

// ===== verif/bridge_model.sv
// Behavioural MOSFET bridge: phase nodes and Vds comparators.
`timescale 1ns/1ps
module bridge_model #(
  parameter int DELAY = 12 // Cycles a phase node takes to swing.
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Gate drive in, comparators out.
  input  wire logic [5:0] gateOn,
  output logic [2:0]      vdsHighBelow,
  output logic [2:0]      vdsLowBelow
);
  logic [2:0] hi;     // High gates of the three phases.
  logic [2:0] node;   // Phase node sits at the bridge supply.
  int         cnt[3]; // Swing timers.
  assign hi = {gateOn[5], gateOn[3], gateOn[1]};
  // Mid-swing neither comparator is below threshold.
  assign vdsHighBelow = node & hi;
  assign vdsLowBelow  = ~node & ~hi;
  // A node follows its high gate only after DELAY cycles.
  always_ff @(posedge clk) begin
    for (int p = 0; p < 3; p++) begin
      if (rst || hi[p] == node[p]) cnt[p] <= 0;
      else cnt[p] <= cnt[p] + 1;
      if (rst) node[p] <= 1'b0;
      else if (cnt[p] == DELAY - 1) node[p] <= hi[p];
    end
  end
endmodule : bridge_model

// ===== verif/gate_slew_deadtime_pwm_control_tb_top.sv
// Self-checking bench for the gate slew, dead time and PWM block.
`timescale 1ns/1ps
module gate_slew_deadtime_pwm_control_tb_top;
  import gate_pwm_pkg::*;
  // ==========================================================
  // Signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdData;
  logic [2:0]  vdsHighBelow, vdsLowBelow, pwmDemand;
  logic [3:0]  drainSourceThreshold;
  logic [5:0]  gateOn, currentDrive;
  logic [23:0] driveCurrent;
  int          fails = 0;
  int          tests_run = 0;
  always #5 clk = ~clk;
  gate_slew_deadtime_pwm_control DUT (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData),
    .vdsHighBelow(vdsHighBelow), .vdsLowBelow(vdsLowBelow),
    .drainSourceThreshold(drainSourceThreshold), .gateOn(gateOn),
    .currentDrive(currentDrive), .driveCurrent(driveCurrent),
    .pwmDemand(pwmDemand));
  bridge_model #(.DELAY(12)) bridge (.clk(clk), .rst(rst),
    .gateOn(gateOn), .vdsHighBelow(vdsHighBelow),
    .vdsLowBelow(vdsLowBelow));
  // ==========================================================
  // Helpers
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  // One-cycle write; strobe drops at the taking edge, one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask : wr
  // One-cycle read; data is looked at in the following cycle only.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    chk("read data", e, regRdData);
  endtask : rd
  // Selects a gate (0..5) or a PWM demand (6..8).
  function automatic logic probe(input int s);
    return s < 6 ? gateOn[s] : pwmDemand[s-6];
  endfunction : probe
  // Waits, bounded, for a level and returns the cycles spent.
  task automatic waitVal(input int s, input logic v, output int c);
    c = 0;
    while (probe(s) !== v) begin
      @(posedge clk);
      c++;
      if (c > 6000) begin
        fails++;
        $display("wrong value wait %0d exp %0b got timeout", s, v);
        summarize();
      end
    end
  endtask : waitVal
  // ==========================================================
  // Scenarios
  task automatic tReset();
    chk("gates", 0, {pwmDemand, currentDrive, gateOn});
    rd(CTRL_ADDR, CTRL_RST);
    rd(8'h40, 32'h0);
    wr(SLEW_ADDR, 32'hffff_ffff);
    rd(SLEW_ADDR, SLEW_MASK);
    chk("threshold", 4'hf, drainSourceThreshold);
    $display("reset test done");
  endtask : tReset
  // Checks alignment, duty width and period for one mode.
  task automatic tPwm(input logic edgeMode, input int n);
    int a, b, w, x, y;
    wr(DUTY_ADDR, 200);
    wr(DUTY_ADDR + 8'h04, 600);
    wr(DUTY_ADDR + 8'h08, 1000);
    wr(CTRL_ADDR, 32'h4 | (edgeMode << 1) | (n << CTRL_PW_LSB));
    repeat (2) begin
      waitVal(8, 1'b0, a);
      waitVal(8, 1'b1, a);
    end
    waitVal(7, 1'b1, a);
    waitVal(6, 1'b1, b);
    waitVal(6, 1'b0, w);
    waitVal(8, 1'b0, x);
    waitVal(8, 1'b1, y);
    chk("rise gap", edgeMode ? 0 : 200, a);
    chk("rise gap", edgeMode ? 0 : 200, b);
    chk("width", 200, w);
    chk("period", (edgeMode ? 2005 : 2010) + 80 * n, a + b + w + x + y);
    $display("pwm test done mode %0b count %0d", edgeMode, n);
  endtask : tPwm
  // Slew mode with zero currents: switched edges, dead time between.
  task automatic tDead(input int n);
    int c, g, e;
    e = (n * 5 < 10) ? 10 : n * 5;
    wr(SLEW_ADDR, 32'h0);
    wr(DUTY_ADDR, 500);
    wr(CTRL_ADDR, 32'h7 | (n << CTRL_DT_LSB));
    waitVal(0, 1'b1, c);
    waitVal(0, 1'b0, c);
    waitVal(1, 1'b1, g);
    chk("dead on", 1, g >= e && g <= e + 2);
    chk("switched on", 0, currentDrive);
    waitVal(1, 1'b0, c);
    chk("switched off", 0, currentDrive);
    waitVal(0, 1'b1, g);
    chk("dead off", 1, g >= e && g <= e + 2);
    $display("dead time test done count %0d", n);
  endtask : tDead
  // Counts cycles that a slot shows current drive with one code.
  task automatic hold(input logic [3:0] i, input int e, input string nm);
    int k;
    k = 0;
    while (currentDrive[1] === 1'b1 && driveCurrent[7:4] === i) begin
      @(posedge clk);
      k++;
      if (k > 99) begin
        fails++;
        $display("wrong value %s exp below 100 got timeout", nm);
        summarize();
      end
    end
    if (e > 0) chk(nm, e, k);
  endtask : hold
  // Full slew turn-on and turn-off of the phase 0 high gate.
  task automatic tSlew();
    int c;
    wr(SLEW_ADDR, 32'h0712_6953);
    wr(CTRL_ADDR, 32'h001e_0007);
    chk("threshold", 4'h7, drainSourceThreshold);
    waitVal(1, 1'b0, c);
    waitVal(1, 1'b1, c);
    hold(4'h3, 10, "on first");
    hold(4'h5, 0, "on second");
    chk("on detect", 1, vdsHighBelow[0]);
    chk("on hold", 6'h20, {gateOn[1], currentDrive[1], driveCurrent[7:4]});
    waitVal(1, 1'b0, c);
    hold(4'h9, 5, "off first");
    chk("off second", 4'h6, driveCurrent[7:4]);
    hold(4'h6, 0, "off second");
    chk("off detect", 1, vdsLowBelow[0]);
    chk("off hold", 0, {gateOn[1], currentDrive[1]});
    $display("slew test done");
  endtask : tSlew
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    tReset();
    tPwm(1'b0, 1);
    tPwm(1'b1, 3);
    tDead(0);
    tDead(2);
    tDead(3);
    tDead(24);
    tSlew();
    summarize();
  end
endmodule : gate_slew_deadtime_pwm_control_tb_top
